//--- hw/lpps_top.sv
/*
  Pin-state controller: chooses the levels and drives of the general-purpose
  and card pins in full-speed, suspend and hibernate, and catches the compact
  instruction strap during the RTC-domain reset.
  Assumes mode requests, full-speed pin values and configuration come from
  logic on I_CLK; the RTC reset and strap come straight from pins.
*/
// Function
// - in suspend, held pins keep the level and drive from full-speed mode
// - hibernate or halt shutdown: general pins follow hibernate pin-state high/low settings
// - during RTC reset, sample frame-marker strap to enable compact instruction mode
// - hibernate: card strobes and chip selects high if wake-up enabled, else float
// - hibernate: card reset low if wake-up enabled, else float
// - hibernate: card power enable low if wake-up enabled, else high
`timescale 1ns/1ns
module lpps_top
  import lpps_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_RTC_DOMAIN_RESET,
  input wire logic I_FRAME_MARKER,
  input wire logic I_SUSPEND_REQ,
  input wire logic I_HIBERNATE_REQ,
  input wire logic I_HALT_SHUTDOWN_TIMER,
  input wire logic I_WAKE_REQ,
  input wire lpps_pkg::lpps_cfg_t I_CFG,
  input wire lpps_pkg::lpps_gpio_t I_GPIO_FULL,
  input wire lpps_pkg::lpps_card_t I_CARD_FULL,
  output lpps_pkg::lpps_gpio_t O_GPIO,
  output lpps_pkg::lpps_card_t O_CARD,
  output logic O_COMPACT_ISA_STRAP,
  output logic O_MAIN_POWER_REQUEST,
  output lpps_pkg::lpps_state_t O_STATE
);
  import lpps_pkg::*;

  logic [1:0] pin_s;
  logic rtc_rst_s;
  logic strap_s;
  logic [2*GPIO_W-1:0] hib_codes;
  lpps_state_t state_q;
  lpps_state_t state_d;
  lpps_gpio_t gpio_d;
  lpps_card_t card_d;
  lpps_card_t card_hib;
  logic wake_en;
  // per-pin next values are nets so that each pin's slice has its own driver
  wire logic [GPIO_W-1:0] pin_lvl_d;
  wire logic [GPIO_W-1:0] pin_drv_d;

  // the reset line and the strap share one synchroniser so they stay in step
  lpps_sync2 #(
    .W(2)
  ) u_sync (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_async({I_RTC_DOMAIN_RESET, I_FRAME_MARKER}),
    .o_sync(pin_s)
  );

  assign rtc_rst_s = pin_s[1];
  assign strap_s = pin_s[0];
  assign wake_en = I_CFG.card_wakeup_en;
  // codes of pins 31..16 sit in the high word, so pin p owns bits 2p+1:2p
  assign hib_codes = {I_CFG.hib_pin_state_high_reg, I_CFG.hib_pin_state_low_reg};

  // halt shutdown lands in hibernate as well; wake returns to full speed
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_FULL: begin
        if (I_HIBERNATE_REQ || I_HALT_SHUTDOWN_TIMER) begin
          state_d = ST_HIBERNATE;
        end else if (I_SUSPEND_REQ) begin
          state_d = ST_SUSPEND;
        end
      end
      // hibernate outranks wake here, so a halt shutdown in suspend is never lost
      ST_SUSPEND: begin
        if (I_HIBERNATE_REQ || I_HALT_SHUTDOWN_TIMER) begin
          state_d = ST_HIBERNATE;
        end else if (I_WAKE_REQ) begin
          state_d = ST_FULL;
        end
      end
      // only a wake or an RTC reset leaves hibernate; suspend requests are ignored
      ST_HIBERNATE: begin
        if (I_WAKE_REQ) begin
          state_d = ST_FULL;
        end
      end
      default: begin
        state_d = ST_FULL;
      end
    endcase
    if (rtc_rst_s) begin
      state_d = ST_FULL;
    end
  end

  // an illegal one-hot code falls back to full speed through the default item
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= ST_FULL;
    end else begin
      state_q <= state_d;
    end
  end

  // general pins: the code of each pin picks float, hold, low or high
  generate
    for (genvar p = 0; p < GPIO_W; p++) begin : g_pin
      logic [CODE_W-1:0] code;
      logic lvl_d;
      logic drv_d;
      assign code = hib_codes[CODE_W*p +: CODE_W];
      always_comb begin
        lvl_d = O_GPIO.level[p];
        drv_d = O_GPIO.drive[p];
        if (rtc_rst_s) begin
          // level is kept while the drive is off; once reset ends the pin takes its full-speed values
          drv_d = 1'b0;
        end else if (state_q == ST_FULL) begin
          lvl_d = I_GPIO_FULL.level[p];
          drv_d = I_GPIO_FULL.drive[p];
        end else if (state_q == ST_HIBERNATE) begin
          unique case (code)
            HIB_FLOAT: drv_d = 1'b0;
            HIB_HOLD: drv_d = O_GPIO.drive[p];
            HIB_LOW: begin
              lvl_d = 1'b0;
              drv_d = 1'b1;
            end
            HIB_HIGH: begin
              lvl_d = 1'b1;
              drv_d = 1'b1;
            end
          endcase
        end
        // suspend leaves level and drive untouched
      end
      assign pin_lvl_d[p] = lvl_d;
      assign pin_drv_d[p] = drv_d;
    end
  endgenerate

  assign gpio_d = '{level: pin_lvl_d, drive: pin_drv_d};

  // hibernate card drives and the power enable level follow the one wake-up bit
  always_comb begin
    card_hib.level = {CARD_W{1'b1}};
    card_hib.drive = {CARD_W{wake_en}};
    card_hib.reset_level = 1'b0;
    card_hib.reset_drive = wake_en;
    card_hib.power_n = ~wake_en;
  end

  always_comb begin
    card_d = O_CARD;
    if (rtc_rst_s) begin
      // the card side floats while the RTC domain is reset; power enable keeps its level
      card_d.drive = '0;
      card_d.reset_drive = 1'b0;
    end else if (state_q == ST_FULL) begin
      card_d = I_CARD_FULL;
    end else if (state_q == ST_HIBERNATE) begin
      card_d = card_hib;
    end
    // suspend keeps every card pin as full speed left it
  end

  // reset leaves every general pin undriven until full-speed values arrive
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_GPIO.level <= GPIO_RST;
      O_GPIO.drive <= GPIO_RST;
    end else begin
      O_GPIO <= gpio_d;
    end
  end

  // power enable is active low, so reset leaves the card unpowered
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CARD.level <= CARD_RST;
      O_CARD.drive <= CARD_RST;
      O_CARD.reset_level <= 1'b0;
      O_CARD.reset_drive <= 1'b0;
      O_CARD.power_n <= 1'b1;
    end else begin
      O_CARD <= card_d;
    end
  end

  // the strap keeps following the pin while the RTC reset is held, so the
  // value seen at release is the one that counts
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_COMPACT_ISA_STRAP <= STRAP_RST;
    end else if (rtc_rst_s) begin
      O_COMPACT_ISA_STRAP <= strap_s;
    end
  end

  // the supply request drops at the same edge that publishes hibernate
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_MAIN_POWER_REQUEST <= 1'b0;
    end else begin
      O_MAIN_POWER_REQUEST <= !rtc_rst_s && (state_d != ST_HIBERNATE);
    end
  end

  // state is published from its own flop so the port never shows a decode glitch
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_STATE <= ST_FULL;
    end else begin
      O_STATE <= state_d;
    end
  end
endmodule

//--- hw/lpps_pkg.sv
/*
  Shared constants and carriers of the low-power pin-state controller.
  Assumes nothing but a SystemVerilog compiler; no timing lives here.
*/
package lpps_pkg;

  localparam int GPIO_W = 32;
  localparam int HALF_W = 16;
  localparam int CODE_W = 2;
  localparam int CARD_W = 7;

  // card strobe lanes inside lpps_card_t
  localparam int CARD_WR = 0;
  localparam int CARD_RD = 1;
  localparam int CARD_IOW = 2;
  localparam int CARD_IOR = 3;
  localparam int CARD_CS1 = 4;
  localparam int CARD_CS2 = 5;
  localparam int CARD_ATTR = 6;

  // per-pin hibernate code, two bits per general-purpose pin
  localparam logic [1:0] HIB_FLOAT = 2'h0;
  localparam logic [1:0] HIB_HOLD = 2'h1;
  localparam logic [1:0] HIB_LOW = 2'h2;
  localparam logic [1:0] HIB_HIGH = 2'h3;

  localparam logic [GPIO_W-1:0] GPIO_RST = 32'h00000000;
  localparam logic [CARD_W-1:0] CARD_RST = 7'h00;
  localparam logic STRAP_RST = 1'h0;

  typedef enum logic [2:0] {
    ST_FULL = 3'h1,
    ST_SUSPEND = 3'h2,
    ST_HIBERNATE = 3'h4
  } lpps_state_t;

  typedef struct packed {
    logic [GPIO_W-1:0] level;
    logic [GPIO_W-1:0] drive;
  } lpps_gpio_t;

  typedef struct packed {
    logic [CARD_W-1:0] level;
    logic [CARD_W-1:0] drive;
    logic reset_level;
    logic reset_drive;
    logic power_n;
  } lpps_card_t;

  typedef struct packed {
    logic [GPIO_W-1:0] hib_pin_state_high_reg;
    logic [GPIO_W-1:0] hib_pin_state_low_reg;
    logic card_wakeup_en;
  } lpps_cfg_t;

endpackage

//--- hw/lpps_sync2.sv
/*
  Two-stage synchroniser for pin levels entering the system clock domain.
  Assumes the input is a slow level; pulses shorter than one clock may vanish.
*/
`timescale 1ns/1ns
module lpps_sync2 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  // first stage is read by the second stage only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

//--- verif/lpps_checker.sv
/* pin-state checker on lpps_top ports; assumes the rtc reset pin is mostly quiet */
`timescale 1ns/1ns
module lpps_checker
  import lpps_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_RTC_DOMAIN_RESET,
  input wire logic I_SUSPEND_REQ,
  input wire logic I_HIBERNATE_REQ,
  input wire logic I_HALT_SHUTDOWN_TIMER,
  input wire logic I_WAKE_REQ,
  input wire lpps_pkg::lpps_cfg_t I_CFG,
  input wire lpps_pkg::lpps_gpio_t O_GPIO,
  input wire lpps_pkg::lpps_card_t O_CARD,
  input wire logic O_COMPACT_ISA_STRAP,
  input wire lpps_pkg::lpps_state_t O_STATE
);
  import lpps_pkg::*;
  logic [3:0] rtc_q;
  logic quiet;
  logic [63:0] cd;
  logic [31:0] hib_m, hib_d, hib_l;
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rtc_q <= 4'h0;
    end else begin
      rtc_q <= {rtc_q[2:0], I_RTC_DOMAIN_RESET};
    end
  end
  // the rtc reset overrides state and pins, and is seen late through the synchroniser
  assign quiet = !(I_RTC_DOMAIN_RESET || (|rtc_q));
  assign cd = {I_CFG.hib_pin_state_high_reg, I_CFG.hib_pin_state_low_reg};
  always_comb begin
    for (int p = 0; p < GPIO_W; p++) begin
      hib_m[p] = cd[2*p+:2] != HIB_FLOAT;
      hib_d[p] = (cd[2*p+:2] == HIB_HOLD) ? O_GPIO.drive[p] : hib_m[p];
      hib_l[p] = hib_m[p] & ((cd[2*p+:2] == HIB_HOLD) ? O_GPIO.level[p] : cd[2*p]);
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST || !quiet);
  property p_sg; $past(O_STATE) == ST_SUSPEND |-> $stable(O_GPIO); endproperty
  a_sg: assert property (p_sg) else $error("gpio moved in suspend");
  property p_sc; $past(O_STATE) == ST_SUSPEND |-> $stable(O_CARD); endproperty
  a_sc: assert property (p_sc) else $error("card moved in suspend");
  property p_hg;
    $past(O_STATE) == ST_HIBERNATE |->
      O_GPIO.drive == $past(hib_d) && (O_GPIO.level & $past(hib_m)) == $past(hib_l);
  endproperty
  a_hg: assert property (p_hg) else $error("gpio not per code");
  property p_cl;
    $past(O_STATE) == ST_HIBERNATE |->
      O_CARD.level == 7'h7F && O_CARD.drive == {7{$past(I_CFG.card_wakeup_en)}};
  endproperty
  a_cl: assert property (p_cl) else $error("card strobes wrong");
  property p_cr;
    $past(O_STATE) == ST_HIBERNATE |->
      !O_CARD.reset_level && O_CARD.reset_drive == $past(I_CFG.card_wakeup_en);
  endproperty
  a_cr: assert property (p_cr) else $error("card reset wrong");
  property p_cp;
    $past(O_STATE) == ST_HIBERNATE |-> O_CARD.power_n != $past(I_CFG.card_wakeup_en);
  endproperty
  a_cp: assert property (p_cp) else $error("card power wrong");
  property p_eh;
    (I_HIBERNATE_REQ || I_HALT_SHUTDOWN_TIMER) && !I_WAKE_REQ |=> O_STATE == ST_HIBERNATE;
  endproperty
  a_eh: assert property (p_eh) else $error("no hibernate");
  property p_es;
    I_SUSPEND_REQ && O_STATE == ST_FULL && !(I_HIBERNATE_REQ || I_HALT_SHUTDOWN_TIMER)
      |=> O_STATE == ST_SUSPEND;
  endproperty
  a_es: assert property (p_es) else $error("no suspend");
  property p_st; disable iff (I_RST) quiet |-> $stable(O_COMPACT_ISA_STRAP); endproperty
  a_st: assert property (p_st) else $error("strap moved");
  c_su: cover property (O_STATE == ST_SUSPEND);
  c_hw: cover property (O_STATE == ST_HIBERNATE && I_CFG.card_wakeup_en);
  c_st: cover property (disable iff (I_RST) $rose(O_COMPACT_ISA_STRAP));
endmodule
bind lpps_top lpps_checker chk (.*);

//--- verif/lpps_board.sv
/* board side of the strap pin; assumes the bench says when the resistor wins */
`timescale 1ns/1ns
module lpps_board (
  input wire logic i_clk,
  input wire logic i_hold,
  input wire logic i_level,
  output logic o_frame_marker
);
  logic tgl_q = 1'b0;
  // released pin carries display traffic, so a late sample would catch a moving value
  always @(posedge i_clk) tgl_q <= ~tgl_q;
  assign o_frame_marker = i_hold ? i_level : tgl_q;
endmodule

//--- verif/lpps_top_tb_top.sv
/* bench for lpps_top; assumes pins settle one edge after O_STATE changes */
`timescale 1ns/1ns
module lpps_top_tb_top;
  import lpps_pkg::*;
  typedef struct {lpps_gpio_t g; lpps_card_t c; logic [31:0] m; logic s;
    lpps_state_t t;} lpps_note_t;
  logic clk = 0, rst = 1, rtc = 0, hold = 0, lvl = 0, sus = 0, hib = 0, halt = 0;
  logic wake = 0, st, fm, mpr, es = 0;
  lpps_cfg_t cfg = '0;
  lpps_gpio_t gf = '0, g, eg;
  lpps_card_t cf = '0, c, ec;
  lpps_state_t os;
  logic [31:0] s = 32'h00000026, m;
  lpps_note_t q[$], n;
  int fail_count = 0, n_checks = 0;
  always #4 clk = ~clk;
  lpps_board brd (.i_clk(clk), .i_hold(hold), .i_level(lvl), .o_frame_marker(fm));
  lpps_top uut (.I_CLK(clk), .I_RST(rst), .I_RTC_DOMAIN_RESET(rtc), .I_FRAME_MARKER(fm),
    .I_SUSPEND_REQ(sus), .I_HIBERNATE_REQ(hib), .I_HALT_SHUTDOWN_TIMER(halt),
    .I_WAKE_REQ(wake), .I_CFG(cfg), .I_GPIO_FULL(gf), .I_CARD_FULL(cf), .O_GPIO(g),
    .O_CARD(c), .O_COMPACT_ISA_STRAP(st), .O_MAIN_POWER_REQUEST(mpr), .O_STATE(os));
  function automatic logic [31:0] rnd();
    s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t pins %h want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic full_pins();
    gf = {rnd(), rnd()};
    cf = 17'(rnd());
    eg = gf;
    ec = cf;
    m = '1;
  endtask
  task automatic go_hib(input logic w);
    logic [63:0] cd;
    cfg = {rnd(), rnd(), w};
    cd = {cfg.hib_pin_state_high_reg, cfg.hib_pin_state_low_reg};
    for (int p = 0; p < GPIO_W; p++) begin
      m[p] = cd[2*p+:2] != HIB_FLOAT;
      if (cd[2*p+:2] != HIB_HOLD) begin
        eg.drive[p] = m[p];
        eg.level[p] = cd[2*p];
      end
    end
    ec = {7'h7F, {7{w}}, 1'b0, w, !w};
    halt = w;
    hib = !w;
    step(1);
    {hib, halt} = 2'h0;
    step(3);
    q.push_back('{eg, ec, m, es, ST_HIBERNATE});
    wake = 1;
    step(1);
    wake = 0;
  endtask
  // monitor takes each note once the pins it describes have settled
  always @(posedge clk) begin
    while (q.size() > 0) begin
      n = q.pop_front();
      check({g.level & n.m, g.drive}, {n.g.level & n.m, n.g.drive});
      check(64'(c), 64'(n.c));
      check(64'(st), 64'(n.s));
      check(64'(os), 64'(n.t));
      check(64'(mpr), 64'(n.t != ST_HIBERNATE));
    end
  end
  initial begin
    step(12);
    rst = 0;
    for (int v = 1; v >= 0; v--) begin
      lvl = v[0];
      hold = 1;
      rtc = 1;
      step(6);
      rtc = 0;
      step(6);
      hold = 0;
      es = v[0];
      full_pins();
      step(3);
      q.push_back('{eg, ec, m, es, ST_FULL});
    end
    sus = 1;
    step(1);
    sus = 0;
    gf = {rnd(), rnd()};
    cf = 17'(rnd());
    step(4);
    q.push_back('{eg, ec, m, es, ST_SUSPEND});
    go_hib(1'b0);
    full_pins();
    step(3);
    q.push_back('{eg, ec, m, es, ST_FULL});
    go_hib(1'b1);
    step(2);
    final_report();
  end
  // the sequence needs about 60 cycles; far beyond that means a hang
  initial begin
    repeat (2000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule
